// ---- common/qpv_consts.vh ----
// Constants for the quadrature position and velocity block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef QPV_CONSTS_VH
`define QPV_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave
`define QPV_ADDR_W 8
`define QPV_OFS_CTRL 8'h00
`define QPV_OFS_STAT 8'h04
`define QPV_OFS_POS 8'h08
`define QPV_OFS_MAXPOS 8'h0C
`define QPV_OFS_VCFG 8'h10
`define QPV_OFS_VPER 8'h14
`define QPV_OFS_VRUN 8'h18
`define QPV_OFS_VEL 8'h1C
`define QPV_OFS_IEN 8'h20
`define QPV_OFS_IRAW 8'h24
`define QPV_OFS_IMSK 8'h28
`define QPV_OFS_ICLR 8'h2C

// Control register fields
`define QPV_CTRL_EN 0
`define QPV_CTRL_CAPAB 1
`define QPV_CTRL_IDXRST 2
`define QPV_CTRL_CLKDIR 3
`define QPV_CTRL_SWAP 4
`define QPV_CTRL_VELEN 5
`define QPV_CTRL_W 6

// Status register fields
`define QPV_STAT_ERR 0
`define QPV_STAT_DIR 1

// Interrupt source bits
`define QPV_IRQ_ERR 0
`define QPV_IRQ_DIR 1
`define QPV_IRQ_TMR 2
`define QPV_IRQ_IDX 3
`define QPV_IRQ_W 4

// Velocity predivider select width (divide by 2**sel, sel 0..7)
`define QPV_PDIV_W 3
`define QPV_PDIV_CNT_W 7

// Reset values
`define QPV_MAXPOS_RST 32'hFFFFFFFF
`define QPV_VPER_RST 32'h00000001

// AXI responses
`define QPV_RESP_OKAY 2'h0
`define QPV_RESP_SLVERR 2'h2

`endif

// ---- core/qpv_sync.v ----
// Two-flop synchroniser for the three encoder inputs.
// Assumes inputs may change at any time relative to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module qpv_sync
(
   // Clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // Raw and synchronised levels
   input wire [2:0] raw_i,
   output reg [2:0] sync_o
);

   reg [2:0] meta_q;

   // First stage feeds only the second stage
   always @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_q <= 3'h0;
         sync_o <= 3'h0;
      end
      else
      begin
         meta_q <= raw_i;
         sync_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- core/qpv_velocity.v ----
// Velocity measurement: predivides count pulses, accumulates over a period.
// Assumes count_i is a one-cycle pulse per position step in either direction.
`timescale 1ns/1ps
`default_nettype none
`include "qpv_consts.vh"
module qpv_velocity
(
   // Clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // Control
   input wire run_i,
   input wire [`QPV_PDIV_W-1:0] pdiv_i,
   input wire [31:0] period_i,
   input wire count_i,
   // Results
   output reg [31:0] running_o,
   output reg [31:0] final_o,
   output reg expire_o
);

   reg [`QPV_PDIV_CNT_W-1:0] pdiv_q;
   reg [31:0] tmr_q;
   wire [`QPV_PDIV_CNT_W-1:0] pdiv_lim;
   wire div_pulse;
   wire tmr_done;

   assign pdiv_lim = (`QPV_PDIV_CNT_W'h1 << pdiv_i) - `QPV_PDIV_CNT_W'h1;
   assign div_pulse = count_i && (pdiv_q == pdiv_lim);
   // Zero period is treated as one so the timer can never stall
   assign tmr_done = (tmr_q + 32'h1 >= period_i);

   always @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pdiv_q <= `QPV_PDIV_CNT_W'h0;
         tmr_q <= 32'h0;
         running_o <= 32'h0;
         final_o <= 32'h0;
         expire_o <= 1'b0;
      end
      else if (!run_i)
      begin
         pdiv_q <= `QPV_PDIV_CNT_W'h0;
         tmr_q <= 32'h0;
         running_o <= 32'h0;
         expire_o <= 1'b0;
      end
      else
      begin
         expire_o <= tmr_done;
         if (count_i)
            pdiv_q <= div_pulse ? `QPV_PDIV_CNT_W'h0 : pdiv_q + `QPV_PDIV_CNT_W'h1;
         if (tmr_done)
         begin
            tmr_q <= 32'h0;
            final_o <= running_o + {31'h0, div_pulse};
            running_o <= 32'h0;
         end
         else
         begin
            tmr_q <= tmr_q + 32'h1;
            running_o <= running_o + {31'h0, div_pulse};
         end
      end
   end
endmodule
`default_nettype wire

// ---- core/qpv_top.v ----
// Quadrature position and velocity block with an AXI4-Lite register slave.
// Assumes encoder inputs are free-running levels; one clock, async reset.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "qpv_consts.vh"
module qpv_top
(
   // Clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // Encoder pins
   input wire phase_a_input_i,
   input wire phase_b_input_i,
   input wire index_i,
   // AXI4-Lite write address and data
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [`QPV_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   output reg [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   input wire [`QPV_ADDR_W-1:0] s_axi_araddr,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   // Interrupt
   output reg irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state

   reg [`QPV_CTRL_W-1:0] ctrl_q;
   reg [31:0] pos_q;
   reg [31:0] maxpos_q;
   reg [`QPV_PDIV_W-1:0] vcfg_q;
   reg [31:0] vper_q;
   reg [`QPV_IRQ_W-1:0] ien_q;
   reg [`QPV_IRQ_W-1:0] iraw_q;
   reg err_q;
   reg dir_q;
   reg [2:0] prev_q;
   reg aw_got_q;
   reg w_got_q;
   reg [`QPV_ADDR_W-1:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   wire [2:0] sync_w;
   wire [31:0] vrun_w;
   wire [31:0] vel_w;
   wire vexp_w;

   // Byte-lane merge, used by the CTRL, POS, MAXPOS and VPER writes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisation and decoding

   qpv_sync u_sync
   (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .raw_i({index_i, phase_b_input_i, phase_a_input_i}),
      .sync_o(sync_w)
   );

   wire en = ctrl_q[`QPV_CTRL_EN];
   wire swap = ctrl_q[`QPV_CTRL_SWAP];
   wire ph_a = swap ? sync_w[1] : sync_w[0];
   wire ph_b = swap ? sync_w[0] : sync_w[1];
   wire idx = sync_w[2];
   wire pa_a = prev_q[0];
   wire pa_b = prev_q[1];
   wire a_chg = ph_a ^ pa_a;
   wire b_chg = ph_b ^ pa_b;
   wire idx_rise = idx & ~prev_q[2];
   wire clkdir = ctrl_q[`QPV_CTRL_CLKDIR];
   wire both = ctrl_q[`QPV_CTRL_CAPAB];

   // Quadrature: A leading B is forward
   reg step;
   reg fwd;
   always @*
   begin
      step = 1'b0;
      fwd = dir_q;
      if (clkdir)
      begin
         step = ph_a & ~pa_a;
         fwd = ~ph_b;
      end
      else if (a_chg && !b_chg)
      begin
         step = 1'b1;
         fwd = (ph_a != ph_b);
      end
      else if (b_chg && !a_chg)
      begin
         step = both;
         fwd = (ph_a == ph_b);
      end
   end

   wire count = en & step;
   wire phase_err = en & ~clkdir & a_chg & b_chg;
   wire dir_evt = count & (fwd != dir_q);
   wire idx_evt = en & idx_rise;

   ////////////////////////////////////////////////////////////////////////////
   // Velocity

   qpv_velocity u_vel
   (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .run_i(en & ctrl_q[`QPV_CTRL_VELEN]),
      .pdiv_i(vcfg_q),
      .period_i(vper_q),
      .count_i(count),
      .running_o(vrun_w),
      .final_o(vel_w),
      .expire_o(vexp_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus write channel capture

   wire aw_have = aw_got_q | s_axi_awvalid;
   wire w_have = w_got_q | s_axi_wvalid;
   wire [`QPV_ADDR_W-1:0] wa = aw_got_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wd = w_got_q ? wdata_q : s_axi_wdata;
   wire [3:0] ws = w_got_q ? wstrb_q : s_axi_wstrb;
   wire wr_go = aw_have & w_have & ~s_axi_bvalid;
   wire wr_ctrl = wr_go && (wa == `QPV_OFS_CTRL);
   wire wr_pos = wr_go && (wa == `QPV_OFS_POS);
   wire wr_max = wr_go && (wa == `QPV_OFS_MAXPOS);
   wire wr_vcfg = wr_go && (wa == `QPV_OFS_VCFG);
   wire wr_vper = wr_go && (wa == `QPV_OFS_VPER);
   wire wr_ien = wr_go && (wa == `QPV_OFS_IEN);
   wire wr_iclr = wr_go && (wa == `QPV_OFS_ICLR);
   wire wr_ok = wr_ctrl | wr_pos | wr_max | wr_vcfg | wr_vper | wr_ien | wr_iclr;
   wire [31:0] wmerge_ctrl = merge({{(32-`QPV_CTRL_W){1'b0}}, ctrl_q}, wd, ws);
   wire [31:0] wmerge_pos = merge(pos_q, wd, ws);
   wire [31:0] wmerge_max = merge(maxpos_q, wd, ws);
   wire [31:0] wmerge_vper = merge(vper_q, wd, ws);

   always @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `QPV_RESP_OKAY;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= {`QPV_ADDR_W{1'b0}};
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_q <= s_axi_awaddr;
            aw_got_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_got_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `QPV_RESP_OKAY : `QPV_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration, position and flags

   wire [31:0] pos_inc = (pos_q >= maxpos_q) ? 32'h0 : pos_q + 32'h1;
   wire [31:0] pos_dec = (pos_q == 32'h0) ? maxpos_q : pos_q - 32'h1;
   wire [`QPV_IRQ_W-1:0] ev = {idx_evt, vexp_w, dir_evt, phase_err};
   wire [`QPV_IRQ_W-1:0] clr = wr_iclr ? wd[`QPV_IRQ_W-1:0] : {`QPV_IRQ_W{1'b0}};

   always @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_q <= {`QPV_CTRL_W{1'b0}};
         pos_q <= 32'h0;
         maxpos_q <= `QPV_MAXPOS_RST;
         vcfg_q <= {`QPV_PDIV_W{1'b0}};
         vper_q <= `QPV_VPER_RST;
         ien_q <= {`QPV_IRQ_W{1'b0}};
         iraw_q <= {`QPV_IRQ_W{1'b0}};
         err_q <= 1'b0;
         dir_q <= 1'b1;
         prev_q <= 3'h0;
         irq_o <= 1'b0;
      end
      else
      begin
         prev_q <= {idx, ph_b, ph_a};
         if (wr_ctrl)
            ctrl_q <= wmerge_ctrl[`QPV_CTRL_W-1:0];
         if (wr_max)
            maxpos_q <= wmerge_max;
         if (wr_vcfg && ws[0])
            vcfg_q <= wd[`QPV_PDIV_W-1:0];
         if (wr_vper)
            vper_q <= wmerge_vper;
         if (wr_ien)
            ien_q <= wd[`QPV_IRQ_W-1:0];
         // Software write wins over a same-cycle count
         if (wr_pos)
            pos_q <= wmerge_pos;
         else if (idx_evt && ctrl_q[`QPV_CTRL_IDXRST])
            pos_q <= dir_q ? 32'h0 : maxpos_q;
         else if (count)
            pos_q <= fwd ? pos_inc : pos_dec;
         if (count)
            dir_q <= fwd;
         // Error stays set until acknowledged through the clear register
         if (phase_err)
            err_q <= 1'b1;
         else if (clr[`QPV_IRQ_ERR])
            err_q <= 1'b0;
         iraw_q <= (iraw_q & ~clr) | ev;
         irq_o <= |(((iraw_q & ~clr) | ev) & ien_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus read channel

   always @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `QPV_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `QPV_RESP_OKAY;
         s_axi_rdata <= 32'h0;
         if (s_axi_araddr == `QPV_OFS_CTRL)
            s_axi_rdata <= {{(32-`QPV_CTRL_W){1'b0}}, ctrl_q};
         else if (s_axi_araddr == `QPV_OFS_STAT)
            s_axi_rdata <= {30'h0, dir_q, err_q};
         else if (s_axi_araddr == `QPV_OFS_POS)
            s_axi_rdata <= pos_q;
         else if (s_axi_araddr == `QPV_OFS_MAXPOS)
            s_axi_rdata <= maxpos_q;
         else if (s_axi_araddr == `QPV_OFS_VCFG)
            s_axi_rdata <= {29'h0, vcfg_q};
         else if (s_axi_araddr == `QPV_OFS_VPER)
            s_axi_rdata <= vper_q;
         else if (s_axi_araddr == `QPV_OFS_VRUN)
            s_axi_rdata <= vrun_w;
         else if (s_axi_araddr == `QPV_OFS_VEL)
            s_axi_rdata <= vel_w;
         else if (s_axi_araddr == `QPV_OFS_IEN)
            s_axi_rdata <= {28'h0, ien_q};
         else if (s_axi_araddr == `QPV_OFS_IRAW)
            s_axi_rdata <= {28'h0, iraw_q};
         else if (s_axi_araddr == `QPV_OFS_IMSK)
            s_axi_rdata <= {28'h0, iraw_q & ien_q};
         else if (s_axi_araddr == `QPV_OFS_ICLR)
            s_axi_rdata <= 32'h0;
         else
            s_axi_rresp <= `QPV_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- verification/qpv_monitor.sv ----
// Checker for the register bus and interrupt line of qpv_top.
// Assumes it is bound to qpv_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "qpv_consts.vh"
module qpv_monitor
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   // Interrupt
   input wire logic irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   logic wr_take;
   logic [3:0] ien_q;
   assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // Shadow of the enable mask; the bench always offers address and data together
   always @(posedge core_clk_i or negedge resetn_i)
      if (!resetn_i)
         ien_q <= 4'h0;
      else if (wr_take && s_axi_awaddr == `QPV_OFS_IEN)
         ien_q <= s_axi_wdata[3:0];
   ////////////////////////////////////////
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_write_answer: assert property (wr_take |=> s_axi_bvalid && !s_axi_awready)
      else $error("write not answered");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read not answered");
   a_write_reopen: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not reopened");
   a_read_reopen: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid && s_axi_arready) else $error("read not reopened");
   a_status_ro: assert property (wr_take && s_axi_awaddr == `QPV_OFS_STAT |=>
      s_axi_bresp == `QPV_RESP_SLVERR) else $error("status write accepted");
   a_clear_reads_zero: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == `QPV_OFS_ICLR |=> s_axi_rdata == 32'h0) else $error("clear reg read");
   a_irq_masked: assert property (ien_q == 4'h0 [*2] |-> !irq_o)
      else $error("interrupt with all sources disabled");
   c_refused: cover property (s_axi_bvalid && s_axi_bresp == `QPV_RESP_SLVERR);
   c_irq: cover property (irq_o);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind qpv_top qpv_monitor qpv_monitor_i (.core_clk_i, .resetn_i, .s_axi_awvalid,
   .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq_o);
`default_nettype wire

// ---- verification/qpv_enc_model.sv ----
// Behavioural rotary encoder with index output.
// Assumes the caller steps it from a process synchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module qpv_enc_model
(
   // Clock
   input wire logic core_clk_i,
   // Encoder pins
   output logic phase_a_o,
   output logic phase_b_o,
   output logic index_o
);
   initial phase_a_o = 1'h0;
   initial phase_b_o = 1'h0;
   initial index_o = 1'h0;
   // Gap sets the pace; it must exceed the sync delay for the bench to read back
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // Forward has A leading B
   task automatic quad(input logic fwd, input int gap);
      if ((phase_a_o == phase_b_o) == fwd)
         phase_a_o <= ~phase_a_o;
      else
         phase_b_o <= ~phase_b_o;
      hold(gap);
   endtask
   // Step clock on A, direction level on B (low means forward)
   task automatic cd(input logic fwd, input int gap);
      phase_a_o <= 1'h0;
      phase_b_o <= ~fwd;
      hold(gap);
      phase_a_o <= 1'h1;
      hold(gap);
   endtask
   // Faulty encoder: both phases flip together
   task automatic glitch(input int gap);
      phase_a_o <= ~phase_a_o;
      phase_b_o <= ~phase_b_o;
      hold(gap);
   endtask
   task automatic pulse(input int gap);
      index_o <= 1'h1;
      hold(gap);
      index_o <= 1'h0;
      hold(gap);
   endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for qpv_top driven through its register bus.
// Assumes the encoder model on the pins and the monitor bound to the top.
`timescale 1ns/1ps
`default_nettype none
`include "qpv_consts.vh"
module tb_top;
   logic core_clk = 1'h0;
   logic resetn = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, dat, keep;
   logic [1:0] resp;
   wire awready, wready, bvalid, arready, rvalid, irq, pa, pb, idx;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int error_cnt = 0;
   int samples_checked = 0;
   always #2 core_clk = ~core_clk;
   qpv_enc_model qpv_enc_model_i (.core_clk_i(core_clk), .phase_a_o(pa), .phase_b_o(pb),
      .index_o(idx));
   qpv_top qpv_top_i (.core_clk_i(core_clk), .resetn_i(resetn), .phase_a_input_i(pa),
      .phase_b_input_i(pb), .index_i(idx), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .irq_o(irq));
   ////////////////////////////////////////
   task automatic wrap_up();
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bready waits a cycle so the slave must hold its answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_d, w_d;
      aw_d = 1'h0;
      w_d = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(aw_d && w_d))
      begin
         @(posedge core_clk);
         if (!aw_d && awready)
         begin
            aw_d = 1'h1;
            awvalid <= 1'h0;
         end
         if (!w_d && wready)
         begin
            w_d = 1'h1;
            wvalid <= 1'h0;
         end
      end
      @(posedge core_clk);
      bready <= 1'h1;
      do @(posedge core_clk); while (!bvalid);
      bready <= 1'h0;
      resp = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 1'h0;
      @(posedge core_clk);
      rready <= 1'h1;
      do @(posedge core_clk); while (!rvalid);
      rready <= 1'h0;
      dat = rdata;
      resp = rresp;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(dat, e);
   endtask
   // Config lands with the block disabled, so a swap or mode change cannot fake an edge
   task automatic cfg(input logic [31:0] c);
      wr(`QPV_OFS_CTRL, c & 32'hFFFFFFFE);
      wr(`QPV_OFS_CTRL, c);
   endtask
   task automatic steps(input logic fwd, input int n);
      repeat (n) qpv_enc_model_i.quad(fwd, 4);
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      rchk(`QPV_OFS_CTRL, 32'h0);
      rchk(`QPV_OFS_MAXPOS, `QPV_MAXPOS_RST);
      rchk(`QPV_OFS_VPER, `QPV_VPER_RST);
      rchk(`QPV_OFS_STAT, 32'h2);
      rchk(`QPV_OFS_ICLR, 32'h0);
      rd(8'h30);
      chk({30'h0, resp}, {30'h0, `QPV_RESP_SLVERR});
      wr(`QPV_OFS_STAT, 32'h3);
      chk({30'h0, resp}, {30'h0, `QPV_RESP_SLVERR});
   endtask
   task automatic t_count();
      wr(`QPV_OFS_MAXPOS, 32'h5);
      chk({30'h0, resp}, {30'h0, `QPV_RESP_OKAY});
      cfg(32'h3);
      wr(`QPV_OFS_ICLR, 32'hF);
      wr(`QPV_OFS_POS, 32'h4);
      steps(1'h1, 4);
      rchk(`QPV_OFS_POS, 32'h2);
      steps(1'h0, 3);
      rchk(`QPV_OFS_POS, 32'h5);
      rchk(`QPV_OFS_STAT, 32'h0);
      rd(`QPV_OFS_IRAW);
      chk(dat & 32'h2, 32'h2);
      cfg(32'h1);
      wr(`QPV_OFS_POS, 32'h0);
      steps(1'h1, 4);
      rchk(`QPV_OFS_POS, 32'h2);
      cfg(32'h13);
      wr(`QPV_OFS_POS, 32'h0);
      steps(1'h1, 2);
      rchk(`QPV_OFS_POS, 32'h4);
      cfg(32'h9);
      wr(`QPV_OFS_POS, 32'h1);
      repeat (3) qpv_enc_model_i.cd(1'h1, 4);
      rchk(`QPV_OFS_POS, 32'h4);
      repeat (2) qpv_enc_model_i.cd(1'h0, 4);
      rchk(`QPV_OFS_POS, 32'h2);
   endtask
   task automatic t_index();
      cfg(32'h7);
      wr(`QPV_OFS_POS, 32'h3);
      steps(1'h1, 1);
      qpv_enc_model_i.pulse(4);
      rchk(`QPV_OFS_POS, 32'h0);
      wr(`QPV_OFS_POS, 32'h3);
      steps(1'h0, 1);
      qpv_enc_model_i.pulse(4);
      rchk(`QPV_OFS_POS, 32'h5);
   endtask
   task automatic t_irq();
      cfg(32'h3);
      wr(`QPV_OFS_IEN, 32'h0);
      wr(`QPV_OFS_ICLR, 32'hF);
      qpv_enc_model_i.glitch(4);
      rd(`QPV_OFS_STAT);
      chk(dat & 32'h1, 32'h1);
      rchk(`QPV_OFS_IMSK, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`QPV_OFS_IEN, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rchk(`QPV_OFS_IMSK, 32'h1);
      rd(`QPV_OFS_POS);
      keep = dat;
      qpv_enc_model_i.pulse(4);
      rchk(`QPV_OFS_POS, keep);
      rd(`QPV_OFS_IRAW);
      chk(dat & 32'h9, 32'h9);
      wr(`QPV_OFS_ICLR, 32'h1);
      rd(`QPV_OFS_IRAW);
      chk(dat & 32'h9, 32'h8);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_velocity();
      wr(`QPV_OFS_VCFG, 32'h1);
      wr(`QPV_OFS_VPER, 32'h12C);
      cfg(32'h23);
      do rd(`QPV_OFS_IRAW); while (!dat[2]);
      wr(`QPV_OFS_ICLR, 32'h4);
      steps(1'h1, 8);
      rchk(`QPV_OFS_VRUN, 32'h4);
      do rd(`QPV_OFS_IRAW); while (!dat[2]);
      rchk(`QPV_OFS_VEL, 32'h4);
      wr(`QPV_OFS_CTRL, 32'h22);
      rd(`QPV_OFS_POS);
      keep = dat;
      steps(1'h1, 2);
      rchk(`QPV_OFS_POS, keep);
      rchk(`QPV_OFS_VRUN, 32'h0);
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge core_clk);
      resetn <= 1'h1;
      @(posedge core_clk);
      t_reset();
      t_count();
      t_index();
      t_irq();
      t_velocity();
      wrap_up();
   end
   // Whole run needs about a thousand cycles; the limit of 25000 cycles allows a wide margin
   initial
   begin
      #100000;
      error_cnt++;
      $display("Error %0t: timeout", $time);
      wrap_up();
   end
endmodule
`default_nettype wire
